// File: rtl/ppcsr_pkg.sv
// package: register map, field positions and reset values of the clock and power manager block
package ppcsr_pkg;
  // register offsets
  localparam logic [15:0] OFS_PIX_CTL = 16'h7000;
  localparam logic [15:0] OFS_PIX_CFG0 = 16'h7004;
  localparam logic [15:0] OFS_PIX_CFG1 = 16'h7008;
  localparam logic [15:0] OFS_SYS_CTL = 16'h700C;
  localparam logic [15:0] OFS_SYS_CFG0 = 16'h7010;
  localparam logic [15:0] OFS_SYS_CFG1 = 16'h7014;
  localparam logic [15:0] OFS_PM_CTL = 16'h7020;
  localparam logic [15:0] OFS_SPACE_BASE = 16'h7000;
  localparam logic [15:0] OFS_SPACE_LAST = 16'h7FFF;
  // control register field positions
  localparam int POS_GATE = 31;
  localparam int POS_LOCK1 = 5;
  localparam int POS_LOCK0 = 4;
  localparam int POS_PASS1 = 3;
  localparam int POS_PASS0 = 2;
  localparam int POS_HOLD1 = 1;
  localparam int POS_HOLD0 = 0;
  // stage configuration field positions
  localparam int POS_BAND_LO = 20;
  localparam int POS_OUTDIV_LO = 16;
  localparam int POS_REFDIV_LO = 8;
  localparam int POS_FBDIV_LO = 0;
  // writable masks
  localparam logic [31:0] MASK_CTL = 32'h8000000F;
  localparam logic [31:0] MASK_CFG = 32'h00771FFF;
  localparam logic [31:0] MASK_PM = 32'h0000001F;
  // power manager control fields (placement of the low bits is local)
  localparam int POS_JPG_SRC = 2;
  localparam int POS_XTAL_KEEP = 1;
  localparam int POS_AUTO_SUSPEND = 3;
  localparam int POS_SELF_REFRESH = 4;
  // reset values and the rejected output divide code
  localparam logic [31:0] RST_CTL = 32'h8000000F;
  localparam logic [31:0] RST_CFG = 32'h00000000;
  localparam logic [31:0] RST_PM = 32'h00000000;
  localparam logic [2:0] OUTDIV_INVALID = 3'h7;
  // manager power states and link power states
  typedef enum logic [5:0] {
    PPCSR_ST_UNCONF = 6'h01,
    PPCSR_ST_CONF = 6'h02,
    PPCSR_ST_SLEEP = 6'h04,
    PPCSR_ST_SUSPEND = 6'h08,
    PPCSR_ST_RESUME = 6'h10,
    PPCSR_ST_OFF = 6'h20
  } ppcsr_state_t;
  typedef enum logic [2:0] {
    PPCSR_LINK_ON = 3'h0,
    PPCSR_LINK_L1 = 3'h1,
    PPCSR_LINK_L2 = 3'h2,
    PPCSR_LINK_U1 = 3'h3,
    PPCSR_LINK_U2 = 3'h4,
    PPCSR_LINK_U3 = 3'h5,
    PPCSR_LINK_OFF = 3'h6
  } ppcsr_link_t;
endpackage

// File: rtl/ppcsr_pll_if.sv
// interface: controls and status of one two-stage pll passed between top and stage controller
`timescale 1ns/1ns
interface ppcsr_pll_if;
  logic [31:0] ctl;
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic enable;
  logic [1:0] lock_raw;
  logic [1:0] lock_sync;
  logic [1:0] pass;
  logic [1:0] hold;
  logic gate;
  modport csr (output ctl, output cfg0, output cfg1, output enable, output lock_raw,
    input lock_sync, input pass, input hold, input gate);
  modport ctrl (input ctl, input cfg0, input cfg1, input enable, input lock_raw,
    output lock_sync, output pass, output hold, output gate);
endinterface

// File: rtl/ppcsr_pll_ctrl.sv
// module: per-pll stage controls with lock synchronisers
`timescale 1ns/1ns
module ppcsr_pll_ctrl (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  ppcsr_pll_if.ctrl pll
);
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_c;
  logic [1:0] lock_q;
  logic [1:0] next_lock;

  ////////////////////////////////////////////////////////////////////////////
  // lock bits are asynchronous; three flops, change taken when last two agree
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      sync_c <= 2'h0;
      lock_q <= 2'h0;
    end else begin
      sync_a <= pll.lock_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
      lock_q <= next_lock;
    end
  end

  // per-stage filter: keep old value while the two late flops disagree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_stage
      assign next_lock[g] = (sync_b[g] == sync_c[g]) ? sync_c[g] : lock_q[g];
      // a powered-down pll is forced to bypass and hold-off
      assign pll.pass[g] = pll.ctl[ppcsr_pkg::POS_PASS0 + g] | ~pll.enable;
      assign pll.hold[g] = pll.ctl[ppcsr_pkg::POS_HOLD0 + g] | ~pll.enable;
    end
  endgenerate

  assign pll.lock_sync = lock_q;
  // gate forced on while the manager has the pll off, so clocks never glitch out
  assign pll.gate = pll.ctl[ppcsr_pkg::POS_GATE] | ~pll.enable;
endmodule

// File: rtl/ppcsr_lowpower.sv
// module: maps link power states to power manager actions
`timescale 1ns/1ns
module ppcsr_lowpower (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_configured,
  input wire ppcsr_pkg::ppcsr_link_t i_link,
  input wire logic i_auto_suspend,
  output ppcsr_pkg::ppcsr_state_t o_state,
  output logic o_auto_active
);
  ppcsr_pkg::ppcsr_state_t state;
  ppcsr_pkg::ppcsr_state_t next_state;
  logic suspend_req;
  logic sleep_req;

  ////////////////////////////////////////////////////////////////////////////
  // l2 and u3 both read as ordinary suspend; u1/u2 cost nothing
  assign suspend_req = (i_link == ppcsr_pkg::PPCSR_LINK_L2) |
    (i_link == ppcsr_pkg::PPCSR_LINK_U3);
  assign sleep_req = (i_link == ppcsr_pkg::PPCSR_LINK_L1);

  // state choice
  always_comb begin
    next_state = state;
    case (state)
      ppcsr_pkg::PPCSR_ST_UNCONF: begin
        if (i_configured) next_state = ppcsr_pkg::PPCSR_ST_CONF;
        else if (suspend_req) next_state = ppcsr_pkg::PPCSR_ST_SUSPEND;
      end
      ppcsr_pkg::PPCSR_ST_CONF: begin
        if (i_link == ppcsr_pkg::PPCSR_LINK_OFF) next_state = ppcsr_pkg::PPCSR_ST_OFF;
        else if (suspend_req) next_state = ppcsr_pkg::PPCSR_ST_SUSPEND;
        else if (sleep_req) next_state = ppcsr_pkg::PPCSR_ST_SLEEP;
        else if (!i_configured) next_state = ppcsr_pkg::PPCSR_ST_UNCONF;
      end
      ppcsr_pkg::PPCSR_ST_SLEEP: begin
        if (suspend_req) next_state = ppcsr_pkg::PPCSR_ST_SUSPEND;
        else if (!sleep_req) next_state = ppcsr_pkg::PPCSR_ST_CONF;
      end
      ppcsr_pkg::PPCSR_ST_SUSPEND: begin
        if (!suspend_req) next_state = ppcsr_pkg::PPCSR_ST_RESUME;
      end
      ppcsr_pkg::PPCSR_ST_RESUME: begin
        next_state = i_configured ? ppcsr_pkg::PPCSR_ST_CONF : ppcsr_pkg::PPCSR_ST_UNCONF;
      end
      ppcsr_pkg::PPCSR_ST_OFF: begin
        if (i_link != ppcsr_pkg::PPCSR_LINK_OFF) next_state = ppcsr_pkg::PPCSR_ST_UNCONF;
      end
      default: next_state = ppcsr_pkg::PPCSR_ST_UNCONF;
    endcase
  end

  // state register; auto flag marks suspend entered under the manager's own control
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state <= ppcsr_pkg::PPCSR_ST_UNCONF;
      o_auto_active <= 1'b0;
    end else begin
      state <= next_state;
      o_auto_active <= (next_state == ppcsr_pkg::PPCSR_ST_SUSPEND) & i_auto_suspend;
    end
  end

  assign o_state = state;
endmodule

// File: rtl/ppcsr_top.sv
// module: clock and power manager register bank, pll controls and power actions
// How it works
// - registers run on the crystal clock, usable before any pll runs.
// - six pll registers from 7000h, manager control at 7020h, rest reserved.
// - bit 31 gates pixel pll clocks, resets set, start and stop glitch-free.
// - bits 5 and 4 show stage 1 and 0 lock, reset zero.
// - bit 3 powers down stage 1, output follows stage 0 node.
// - bit 2 powers down stage 0, its node follows the reference.
// - bit 1 powers down stage 1 and holds final output low.
// - bit 0 powers down stage 0 and holds its node low.
// - bits 22:20 pick filter band, 000 bypass, reset zero.
// - bits 18:16 give output divide two to the field; 111 rejected.
// - bits 12:8 hold reference divider minus one, reset zero.
// - bits 7:0 hold feedback divider minus one, reset zero.
// - self refresh entry drops non-clock-enable memory pad output enables.
// - a deselected display port is disabled and its clock stopped.
// - l1 sleep keeps every module powered; l2 is plain suspend.
// - u1 and u2 do nothing, u3 is suspend, u0 is configured.
`timescale 1ns/1ns
module ppcsr_top (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_err,
  input wire logic [1:0] i_pixel_lock,
  input wire logic [1:0] i_system_lock,
  input wire logic i_configured,
  input wire ppcsr_pkg::ppcsr_link_t i_link,
  input wire logic i_display_port0_select,
  input wire logic i_memory_pad_output_disable,
  output logic o_pixel_clock_gate,
  output logic o_pixel_stage0_passthrough,
  output logic o_pixel_stage1_passthrough,
  output logic o_pixel_stage0_hold_off,
  output logic o_pixel_stage1_hold_off,
  output logic [2:0] o_pixel_stage0_filter_band,
  output logic [2:0] o_pixel_stage0_output_divider,
  output logic [4:0] o_pixel_stage0_reference_divider,
  output logic [7:0] o_pixel_stage0_feedback_divider,
  output logic [31:0] o_pixel_stage1_config,
  output logic o_system_clock_gate,
  output logic [3:0] o_system_stage_ctl,
  output logic [31:0] o_system_stage0_config,
  output logic [31:0] o_system_stage1_config,
  output logic o_memory_self_refresh_request,
  output logic o_pad_output_enable,
  output logic o_display_port0_clock_on,
  output logic o_jpeg_clock_from_system,
  output logic o_crystal_keep_alive,
  output logic o_light_reset_needed,
  output logic o_sleep_active
);
  logic [31:0] pixel_pll_control;
  logic [31:0] pixel_pll_stage0_config;
  logic [31:0] pixel_pll_stage1_config;
  logic [31:0] system_pll_control;
  logic [31:0] system_pll_stage0_config;
  logic [31:0] system_pll_stage1_config;
  logic [31:0] power_manager_control;
  logic light_reset_flag;
  ppcsr_pkg::ppcsr_state_t pm_state;
  logic auto_active;
  logic plls_enable;

  ppcsr_pll_if pix_if ();
  ppcsr_pll_if sys_if ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode; whole block is on the crystal clock so access never waits on a pll
  logic in_space;
  logic hit_pix_ctl;
  logic hit_pix_cfg0;
  logic hit_pix_cfg1;
  logic hit_sys_ctl;
  logic hit_sys_cfg0;
  logic hit_sys_cfg1;
  logic hit_pm;
  logic wr_pix_cfg0;
  logic wr_sys_cfg0;
  logic wr_pix_cfg1;
  logic wr_sys_cfg1;
  logic [31:0] read_mux;
  logic [31:0] pix_ctl_view;
  logic [31:0] sys_ctl_view;

  assign in_space = (i_reg_addr >= ppcsr_pkg::OFS_SPACE_BASE) &&
    (i_reg_addr <= ppcsr_pkg::OFS_SPACE_LAST);
  assign hit_pix_ctl = (i_reg_addr == ppcsr_pkg::OFS_PIX_CTL);
  assign hit_pix_cfg0 = (i_reg_addr == ppcsr_pkg::OFS_PIX_CFG0);
  assign hit_pix_cfg1 = (i_reg_addr == ppcsr_pkg::OFS_PIX_CFG1);
  assign hit_sys_ctl = (i_reg_addr == ppcsr_pkg::OFS_SYS_CTL);
  assign hit_sys_cfg0 = (i_reg_addr == ppcsr_pkg::OFS_SYS_CFG0);
  assign hit_sys_cfg1 = (i_reg_addr == ppcsr_pkg::OFS_SYS_CFG1);
  assign hit_pm = (i_reg_addr == ppcsr_pkg::OFS_PM_CTL);

  // a write carrying output divide 111 is dropped whole; the pll must never see it
  assign wr_pix_cfg0 = i_reg_wr & hit_pix_cfg0 &
    (i_reg_wdata[ppcsr_pkg::POS_OUTDIV_LO +: 3] != ppcsr_pkg::OUTDIV_INVALID);
  assign wr_pix_cfg1 = i_reg_wr & hit_pix_cfg1 &
    (i_reg_wdata[ppcsr_pkg::POS_OUTDIV_LO +: 3] != ppcsr_pkg::OUTDIV_INVALID);
  assign wr_sys_cfg0 = i_reg_wr & hit_sys_cfg0 &
    (i_reg_wdata[ppcsr_pkg::POS_OUTDIV_LO +: 3] != ppcsr_pkg::OUTDIV_INVALID);
  assign wr_sys_cfg1 = i_reg_wr & hit_sys_cfg1 &
    (i_reg_wdata[ppcsr_pkg::POS_OUTDIV_LO +: 3] != ppcsr_pkg::OUTDIV_INVALID);

  ////////////////////////////////////////////////////////////////////////////
  // register storage; writable masks keep reserved bits at zero
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pixel_pll_control <= ppcsr_pkg::RST_CTL;
      pixel_pll_stage0_config <= ppcsr_pkg::RST_CFG;
      pixel_pll_stage1_config <= ppcsr_pkg::RST_CFG;
      system_pll_control <= ppcsr_pkg::RST_CTL;
      system_pll_stage0_config <= ppcsr_pkg::RST_CFG;
      system_pll_stage1_config <= ppcsr_pkg::RST_CFG;
      power_manager_control <= ppcsr_pkg::RST_PM;
    end else if (i_reg_wr) begin
      if (hit_pix_ctl) pixel_pll_control <= i_reg_wdata & ppcsr_pkg::MASK_CTL;
      if (wr_pix_cfg0) pixel_pll_stage0_config <= i_reg_wdata & ppcsr_pkg::MASK_CFG;
      if (wr_pix_cfg1) pixel_pll_stage1_config <= i_reg_wdata & ppcsr_pkg::MASK_CFG;
      if (hit_sys_ctl) system_pll_control <= i_reg_wdata & ppcsr_pkg::MASK_CTL;
      if (wr_sys_cfg0) system_pll_stage0_config <= i_reg_wdata & ppcsr_pkg::MASK_CFG;
      if (wr_sys_cfg1) system_pll_stage1_config <= i_reg_wdata & ppcsr_pkg::MASK_CFG;
      if (hit_pm) power_manager_control <= i_reg_wdata & ppcsr_pkg::MASK_PM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read views; lock bits come from the synchronised copy, never the raw pins
  always_comb begin
    pix_ctl_view = pixel_pll_control;
    pix_ctl_view[ppcsr_pkg::POS_LOCK0] = pix_if.lock_sync[0];
    pix_ctl_view[ppcsr_pkg::POS_LOCK1] = pix_if.lock_sync[1];
    sys_ctl_view = system_pll_control;
    sys_ctl_view[ppcsr_pkg::POS_LOCK0] = sys_if.lock_sync[0];
    sys_ctl_view[ppcsr_pkg::POS_LOCK1] = sys_if.lock_sync[1];
  end

  // read select; unmapped words read zero
  assign read_mux = hit_pix_ctl ? pix_ctl_view :
    hit_pix_cfg0 ? pixel_pll_stage0_config :
    hit_pix_cfg1 ? pixel_pll_stage1_config :
    hit_sys_ctl ? sys_ctl_view :
    hit_sys_cfg0 ? system_pll_stage0_config :
    hit_sys_cfg1 ? system_pll_stage1_config :
    hit_pm ? power_manager_control : 32'h00000000;

  // one-cycle answer; error flags any access outside the block's space
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 32'h00000000;
      o_reg_ack <= 1'b0;
      o_reg_err <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? read_mux : 32'h00000000;
      o_reg_ack <= i_reg_rd | i_reg_wr;
      o_reg_err <= (i_reg_rd | i_reg_wr) & ~in_space;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll stage controllers; plls are held off outside the configured and sleep states
  assign plls_enable = (pm_state == ppcsr_pkg::PPCSR_ST_CONF) ||
    (pm_state == ppcsr_pkg::PPCSR_ST_SLEEP);
  assign pix_if.ctl = pixel_pll_control;
  assign pix_if.cfg0 = pixel_pll_stage0_config;
  assign pix_if.cfg1 = pixel_pll_stage1_config;
  assign pix_if.enable = plls_enable;
  assign pix_if.lock_raw = i_pixel_lock;
  assign sys_if.ctl = system_pll_control;
  assign sys_if.cfg0 = system_pll_stage0_config;
  assign sys_if.cfg1 = system_pll_stage1_config;
  assign sys_if.enable = plls_enable;
  assign sys_if.lock_raw = i_system_lock;

  ppcsr_pll_ctrl u_pix (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .pll(pix_if.ctrl)
  );

  ppcsr_pll_ctrl u_sys (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .pll(sys_if.ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link power state mapping
  ppcsr_lowpower u_lp (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_configured(i_configured),
    .i_link(i_link),
    .i_auto_suspend(power_manager_control[ppcsr_pkg::POS_AUTO_SUSPEND]),
    .o_state(pm_state),
    .o_auto_active(auto_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power actions; self refresh is forced during auto suspend so memory survives
  logic self_refresh;
  logic pads_drive;
  logic port0_on;
  logic in_suspend;

  assign in_suspend = (pm_state == ppcsr_pkg::PPCSR_ST_SUSPEND);
  assign self_refresh = power_manager_control[ppcsr_pkg::POS_SELF_REFRESH] | auto_active;
  // self refresh alone drops the pad enables, no separate disable write needed
  assign pads_drive = ~self_refresh & ~i_memory_pad_output_disable;
  // deselected port loses its clock; suspend also stops it
  assign port0_on = i_display_port0_select & ~in_suspend;

  // output flops
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_pixel_clock_gate <= 1'b1;
      o_pixel_stage0_passthrough <= 1'b1;
      o_pixel_stage1_passthrough <= 1'b1;
      o_pixel_stage0_hold_off <= 1'b1;
      o_pixel_stage1_hold_off <= 1'b1;
      o_system_clock_gate <= 1'b1;
      o_system_stage_ctl <= 4'hF;
    end else begin
      o_pixel_clock_gate <= pix_if.gate;
      o_pixel_stage1_passthrough <= pix_if.pass[1];
      o_pixel_stage0_passthrough <= pix_if.pass[0];
      o_pixel_stage1_hold_off <= pix_if.hold[1];
      o_pixel_stage0_hold_off <= pix_if.hold[0];
      o_system_clock_gate <= sys_if.gate;
      o_system_stage_ctl <= {sys_if.pass, sys_if.hold};
    end
  end

  // configuration fields and power action flops
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_pixel_stage0_filter_band <= 3'h0;
      o_pixel_stage0_output_divider <= 3'h0;
      o_pixel_stage0_reference_divider <= 5'h00;
      o_pixel_stage0_feedback_divider <= 8'h00;
      o_pixel_stage1_config <= 32'h00000000;
      o_system_stage0_config <= 32'h00000000;
      o_system_stage1_config <= 32'h00000000;
      o_memory_self_refresh_request <= 1'b0;
      o_pad_output_enable <= 1'b0;
      o_display_port0_clock_on <= 1'b0;
      o_jpeg_clock_from_system <= 1'b0;
      o_crystal_keep_alive <= 1'b0;
      o_sleep_active <= 1'b0;
    end else begin
      o_pixel_stage0_filter_band <= pixel_pll_stage0_config[ppcsr_pkg::POS_BAND_LO +: 3];
      o_pixel_stage0_output_divider <=
        pixel_pll_stage0_config[ppcsr_pkg::POS_OUTDIV_LO +: 3];
      o_pixel_stage0_reference_divider <=
        pixel_pll_stage0_config[ppcsr_pkg::POS_REFDIV_LO +: 5];
      o_pixel_stage0_feedback_divider <=
        pixel_pll_stage0_config[ppcsr_pkg::POS_FBDIV_LO +: 8];
      o_pixel_stage1_config <= pixel_pll_stage1_config;
      o_system_stage0_config <= system_pll_stage0_config;
      o_system_stage1_config <= system_pll_stage1_config;
      o_memory_self_refresh_request <= self_refresh;
      o_pad_output_enable <= pads_drive;
      o_display_port0_clock_on <= port0_on;
      o_jpeg_clock_from_system <= power_manager_control[ppcsr_pkg::POS_JPG_SRC];
      o_crystal_keep_alive <= power_manager_control[ppcsr_pkg::POS_XTAL_KEEP];
      o_sleep_active <= (pm_state == ppcsr_pkg::PPCSR_ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky: auto suspend reset parts of the chip, so resume needs a light reset
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      light_reset_flag <= 1'b0;
    end else if (auto_active) begin
      light_reset_flag <= 1'b1;
    end else if (i_reg_wr & hit_pm & ~i_reg_wdata[ppcsr_pkg::POS_AUTO_SUSPEND]) begin
      light_reset_flag <= 1'b0;
    end
  end

  assign o_light_reset_needed = light_reset_flag;
endmodule

// File: dv/ppcsr_checker.sv
// checker: bus answer, decode, lock and power action properties
`timescale 1ns/1ns
module ppcsr_checker (
  input logic i_core_clk,
  input logic i_nrst,
  input logic i_reg_wr,
  input logic i_reg_rd,
  input logic [15:0] i_reg_addr,
  input logic [31:0] i_reg_wdata,
  input logic [31:0] o_reg_rdata,
  input logic o_reg_ack,
  input logic o_reg_err,
  input logic [1:0] i_pixel_lock,
  input logic i_configured,
  input ppcsr_pkg::ppcsr_link_t i_link,
  input logic i_display_port0_select,
  input logic [2:0] o_pixel_stage0_output_divider,
  input logic o_memory_self_refresh_request,
  input logic o_pad_output_enable,
  input logic o_display_port0_clock_on,
  input logic o_sleep_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // request decode shared by the properties
  wire req = i_reg_wr | i_reg_rd;
  wire rd_only = i_reg_rd & ~i_reg_wr;
  wire in_space = i_reg_addr[15:12] == 4'h7;
  ////////////////////////////////////////
  a_ack_after_req: assert property (req |=> o_reg_ack)
    else $error("ack missing after request");
  a_no_stray_ack: assert property (!req |=> !o_reg_ack)
    else $error("ack without request");
  a_err_outside: assert property (req && !in_space |=> o_reg_err)
    else $error("no error outside the space");
  a_err_inside: assert property (req && in_space |=> !o_reg_err)
    else $error("error inside the space");
  a_reserved_zero: assert property (rd_only && i_reg_addr == 16'h7018 |=> o_reg_rdata == 32'h0)
    else $error("reserved word not zero");
  // lock must be held steady long enough to cross the synchroniser
  a_lock_synced: assert property (
    $stable(i_pixel_lock) [*5] ##0 (rd_only && i_reg_addr == 16'h7000)
    |=> o_reg_rdata[5:4] == $past(i_pixel_lock)) else $error("lock bits wrong");
  a_divq_refused: assert property (
    (i_reg_wr && i_reg_addr == 16'h7004 && i_reg_wdata[18:16] == 3'h7)
    |=> $stable(o_pixel_stage0_output_divider) ##1 $stable(o_pixel_stage0_output_divider))
    else $error("invalid divider accepted");
  a_sref_pads_off: assert property (o_memory_self_refresh_request [*2] |-> !o_pad_output_enable)
    else $error("pads drive in self refresh");
  a_port_clk_off: assert property ((!i_display_port0_select) [*3] |-> !o_display_port0_clock_on)
    else $error("port clock runs while deselected");
  a_l1_sleep: assert property (
    (i_configured && i_link == ppcsr_pkg::PPCSR_LINK_L1) [*6] |-> o_sleep_active)
    else $error("sleep not entered");
  a_u3_suspend: assert property (
    (i_configured && i_link == ppcsr_pkg::PPCSR_LINK_U3) [*4] |-> !o_display_port0_clock_on)
    else $error("port clock runs in suspend");
  c_read_ok: cover property (rd_only && in_space ##1 o_reg_ack);
  c_err_seen: cover property (o_reg_err);
  c_sleep_seen: cover property ($rose(o_sleep_active));
endmodule
bind ppcsr_top ppcsr_checker u_checker (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
  .i_pixel_lock(i_pixel_lock), .i_configured(i_configured), .i_link(i_link),
  .i_display_port0_select(i_display_port0_select),
  .o_pixel_stage0_output_divider(o_pixel_stage0_output_divider),
  .o_memory_self_refresh_request(o_memory_self_refresh_request),
  .o_pad_output_enable(o_pad_output_enable), .o_display_port0_clock_on(o_display_port0_clock_on),
  .o_sleep_active(o_sleep_active));

// File: dv/ppcsr_pll_model.sv
// partner: two-stage pll macro that reports lock a while after a stage is released
`timescale 1ns/1ns
module ppcsr_pll_model #(
  parameter int LOCK_CYCLES = 20
) (
  input wire logic i_core_clk,
  input wire logic [1:0] i_hold,
  input wire logic [1:0] i_pass,
  output logic [1:0] o_lock = 2'h0
);
  int cnt [2];
  // a held or passed stage is powered down, so it drops lock at once
  always @(posedge i_core_clk) begin
    for (int s = 0; s < 2; s++) begin
      if (i_hold[s] || i_pass[s]) begin
        cnt[s] = 0;
        o_lock[s] <= 1'b0;
      end else begin
        cnt[s] = (cnt[s] < LOCK_CYCLES) ? cnt[s] + 1 : cnt[s];
        o_lock[s] <= (cnt[s] == LOCK_CYCLES);
      end
    end
  end
endmodule

// File: dv/pixel_pll_power_control_csr_tb.sv
// testbench: register access, pll bring-up and power state checks
`timescale 1ns/1ns
module pixel_pll_power_control_csr_tb;
  localparam int LOCK = 20;
  localparam logic [15:0] OFS [7] = '{16'h7000, 16'h7004, 16'h7008, 16'h700C, 16'h7010,
    16'h7014, 16'h7020};
  localparam logic [31:0] RST [7] = '{32'h8000000F, 32'h0, 32'h0, 32'h8000000F, 32'h0, 32'h0,
    32'h0};
  localparam ppcsr_pkg::ppcsr_link_t LK [8] = '{ppcsr_pkg::PPCSR_LINK_U1,
    ppcsr_pkg::PPCSR_LINK_U2, ppcsr_pkg::PPCSR_LINK_L1, ppcsr_pkg::PPCSR_LINK_ON,
    ppcsr_pkg::PPCSR_LINK_L2, ppcsr_pkg::PPCSR_LINK_ON, ppcsr_pkg::PPCSR_LINK_U3,
    ppcsr_pkg::PPCSR_LINK_ON};
  localparam logic [3:0] EX [8] = '{4'h1, 4'h1, 4'h3, 4'h1, 4'hC, 4'h9, 4'hC, 4'h9};
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cfgd = 1'b0, sel = 1'b1, pad_dis = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  ppcsr_pkg::ppcsr_link_t link = ppcsr_pkg::PPCSR_LINK_ON;
  logic [31:0] rdata;
  logic [1:0] lock;
  logic ack, err, gate, pass0, pass1, hold0, hold1, sref, pad_oe, port_clk, jpg, keep, sleep, light_reset;
  logic [2:0] band, odiv;
  logic [4:0] rdiv;
  logic [7:0] fdiv;
  int miscompares = 0, checks_done = 0, cycles = 0;
  ppcsr_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .o_reg_err(err), .i_pixel_lock(lock), .i_system_lock(2'h0), .i_configured(cfgd),
    .i_link(link), .i_display_port0_select(sel), .i_memory_pad_output_disable(pad_dis),
    .o_pixel_clock_gate(gate), .o_pixel_stage0_passthrough(pass0),
    .o_pixel_stage1_passthrough(pass1), .o_pixel_stage0_hold_off(hold0),
    .o_pixel_stage1_hold_off(hold1), .o_pixel_stage0_filter_band(band),
    .o_pixel_stage0_output_divider(odiv), .o_pixel_stage0_reference_divider(rdiv),
    .o_pixel_stage0_feedback_divider(fdiv), .o_pixel_stage1_config(), .o_system_clock_gate(),
    .o_system_stage_ctl(), .o_system_stage0_config(), .o_system_stage1_config(),
    .o_memory_self_refresh_request(sref), .o_pad_output_enable(pad_oe),
    .o_display_port0_clock_on(port_clk), .o_jpeg_clock_from_system(jpg),
    .o_crystal_keep_alive(keep), .o_light_reset_needed(light_reset), .o_sleep_active(sleep));
  ppcsr_pll_model #(.LOCK_CYCLES(LOCK)) u_pll (.i_core_clk(i_core_clk), .i_hold({hold1, hold0}),
    .i_pass({pass1, pass0}), .o_lock(lock));
  ////////////////////////////////////////
  // clock, and a cycle ceiling far above the roughly two hundred cycles the run needs
  initial forever #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // one-cycle strobe, answer is looked at in the ack cycle only
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge i_core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, ack}, 32'h1);
    chk({31'h0, err}, {31'h0, e});
  endtask
  task automatic rd32(input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    chk(rdata, exp);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    #1;
    chk({27'h0, gate, pass1, pass0, hold1, hold0}, 32'h1F);
    foreach (OFS[i]) rd32(OFS[i], RST[i]);
    acc(1'b1, 16'h7018, 32'hFFFFFFFF, 1'b0);
    rd32(16'h7018, 32'h0);
    rd32(16'h7024, 32'h0);
    acc(1'b0, 16'h6FFC, 32'h0, 1'b1);
    acc(1'b0, 16'h8000, 32'h0, 1'b1);
    acc(1'b1, 16'h7004, 32'hFFFFFFFF, 1'b0);
    rd32(16'h7004, 32'h0);
    acc(1'b1, 16'h7004, 32'hFFF6FFFF, 1'b0);
    rd32(16'h7004, 32'h00761FFF);
    chk({13'h0, band, odiv, rdiv, fdiv}, 32'h7DFFF);
    for (int b = 7; b >= 0; b--) begin
      acc(1'b1, 16'h7004, {9'h0, 3'(b), 20'h0000F}, 1'b0);
      rd32(16'h7004, {9'h0, 3'(b), 20'h0000F});
    end
    // 25 MHz reference, feedback 16 and band 13-26 MHz keep the oscillator at 400 MHz
    acc(1'b1, 16'h7004, 32'h0030000F, 1'b0);
    @(posedge i_core_clk);
    cfgd <= 1'b1;
    cyc(3);
    acc(1'b1, 16'h7000, 32'h80000000, 1'b0);
    cyc(LOCK + 6);
    rd32(16'h7000, 32'h80000030);
    acc(1'b1, 16'h7000, 32'h0, 1'b0);
    cyc(1);
    chk({27'h0, gate, pass1, pass0, hold1, hold0}, 32'h0);
    acc(1'b1, 16'h7000, 32'hFFFFFFFF, 1'b0);
    cyc(6);
    rd32(16'h7000, 32'h8000000F);
    chk({27'h0, gate, pass1, pass0, hold1, hold0}, 32'h1F);
    acc(1'b1, 16'h7020, 32'hFFFFFFF6, 1'b0);
    rd32(16'h7020, 32'h00000016);
    cyc(2);
    chk({28'h0, jpg, keep, sref, pad_oe}, 32'hE);
    acc(1'b1, 16'h7020, 32'h00000008, 1'b0);
    cyc(2);
    chk({31'h0, pad_oe}, 32'h1);
    foreach (LK[i]) begin
      @(posedge i_core_clk);
      link <= LK[i];
      cyc(6);
      chk({28'h0, light_reset, sref, sleep, port_clk}, {28'h0, EX[i]});
    end
    acc(1'b1, 16'h7020, 32'h0, 1'b0);
    chk({31'h0, light_reset}, 32'h0);
    @(posedge i_core_clk);
    sel <= 1'b0;
    pad_dis <= 1'b1;
    cyc(4);
    chk({30'h0, pad_oe, port_clk}, 32'h0);
    summarize();
  end
endmodule
